/* logic/shift_clock_sampler.v */
// two-flop synchroniser and edge finder for the external shift clock
`timescale 1ns/1ps
`default_nettype none

module shift_clock_sampler (
  // clock and reset
  input  wire clk_sys,
  input  wire rst,
  // raw pin level
  input  wire pin_in,
  // edges seen on the synchronised level, one cycle each
  output reg  rise,
  output reg  fall
);

  reg meta;
  reg stable;
  reg last;

  // meta is read only by stable; edges come from the later stages
  always @(posedge clk_sys) begin
    if (rst) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else begin
      meta   <= pin_in;
      stable <= meta;
      last   <= stable;
      rise   <= stable & ~last;
      fall   <= ~stable & last;
    end
  end

endmodule

`default_nettype wire

/* logic/sync_slave_serial_transmitter.v */
// synchronous slave transmit path with axi4-lite register access
//
// How it works
// - sync mode bit selects synchronous operation
// - clock source cleared: slave, external clock
// - both receive enables clear means transmit
// - port enable gates the whole port
// - shifting identical to master transmit otherwise
// - first written word moves straight to shifter
// - second word waits, empty flag stays clear
// - shifter drained: reload, then set flag
// - flag with both enables wakes from sleep
// - global enable also set: request service
// - nine-bit select makes nine-bit characters
// - transmit enable gates transmission
// - ninth bit comes from control register
// - writing holding register starts a character
// - clock pin received, its driver disabled
// - data changes leading edge, sampled trailing
// - one data bit per shift clock cycle
`timescale 1ns/1ps
`default_nettype none
`include "sync_slave_tx_defines.vh"

module sync_slave_serial_transmitter #(
  parameter ADDR_WIDTH = 8
) (
  // clock and reset
  input  wire                  clk_sys,
  input  wire                  rst,
  // axi4-lite write address
  input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output reg                   s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output reg                   s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output reg                   s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  // transmit_clock_pin: input, output, enable (low drives)
  input  wire                  ck_in,
  output reg                   ck_out,
  output reg                   ck_oe_n,
  // data pin: input, output, enable (low drives)
  input  wire                  dt_in,
  output reg                   dt_out,
  output reg                   dt_oe_n,
  // interrupt and power state
  output reg                   irq,
  output reg                   sleeping,
  output reg                   wake,
  output reg                   isr_request
);

  // software state
  reg [7:0]            transmit_control;
  reg [7:0]            receive_control;
  reg [7:0]            baud_control;
  reg [7:0]            cpu_control;
  reg [`IRQ_WIDTH-1:0] irq_status;
  reg [`IRQ_WIDTH-1:0] irq_enable;

  // transmit datapath
  reg [7:0] transmit_holding;
  reg       holding_full;
  reg [8:0] transmit_shift_register;
  reg       shift_busy;
  reg [3:0] bit_count;
  reg [3:0] char_bits;

  // bus bookkeeping
  reg [ADDR_WIDTH-1:0] aw_addr;
  reg                  aw_have;
  reg [31:0]           w_data;
  reg [3:0]            w_strb;
  reg                  w_have;

  wire ck_rise;
  wire ck_fall;

  shift_clock_sampler u_ck_sampler (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (ck_in),
    .rise    (ck_rise),
    .fall    (ck_fall)
  );

  // true when an offset hits one of our registers
  function mapped;
    input [ADDR_WIDTH-1:0] addr;
    begin
      case (addr[7:0])
        `OFS_TRANSMIT_CONTROL,
        `OFS_RECEIVE_CONTROL,
        `OFS_BAUD_CONTROL,
        `OFS_TRANSMIT_HOLDING,
        `OFS_IRQ_STATUS,
        `OFS_IRQ_CLEAR,
        `OFS_IRQ_ENABLE,
        `OFS_CPU_CONTROL: mapped = 1'b1;
        default:          mapped = 1'b0;
      endcase
    end
  endfunction

  // mode decode
  wire port_enable = receive_control[`RXC_PORT_ENABLE];
  wire sync_mode   = transmit_control[`TXC_SYNC_MODE];
  wire slave_mode  = ~transmit_control[`TXC_CLOCK_SOURCE_SELECT];
  wire rx_selected = receive_control[`RXC_SINGLE_RECEIVE] |
                     receive_control[`RXC_CONTINUOUS_RECEIVE];
  wire transmit_enable = transmit_control[`TXC_TRANSMIT_ENABLE];
  wire tx_active = port_enable & sync_mode & slave_mode &
                   ~rx_selected & transmit_enable;
  // worked out with the status logic further down
  wire wake_cause;

  // leading and trailing edges follow the idle level of the clock
  wire polarity = baud_control[`BAUD_CLOCK_POLARITY];
  wire leading  = polarity ? ck_fall : ck_rise;
  wire trailing = polarity ? ck_rise : ck_fall;

  // bus write decode
  wire do_write   = aw_have & w_have & ~s_axi_bvalid;
  wire wr_hit     = mapped(aw_addr);
  wire wr_lane0   = do_write & wr_hit & w_strb[0];
  wire wr_holding = wr_lane0 &
                    (aw_addr[7:0] == `OFS_TRANSMIT_HOLDING);

  // a word moves from holding into the shifter whenever it is idle and tx_active is set
  wire load_shift = tx_active & holding_full & ~shift_busy;
  wire last_bit   = shift_busy & trailing &
                    (bit_count == char_bits - 4'h1);

  // ---------------------------------------------------------------
  // axi4-lite write channel: address and data taken in either order
  always @(posedge clk_sys) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= {ADDR_WIDTH{1'b0}};
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_have       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_have       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel: answer one cycle after the address
  always @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY
                                              : `RESP_SLVERR;
        case (s_axi_araddr[7:0])
          `OFS_TRANSMIT_CONTROL:
            s_axi_rdata <= {24'h00_0000,
                            transmit_control[7:2],
                            ~shift_busy,
                            transmit_control[0]};
          `OFS_RECEIVE_CONTROL:
            s_axi_rdata <= {24'h00_0000, receive_control};
          `OFS_BAUD_CONTROL:
            s_axi_rdata <= {24'h00_0000, baud_control};
          `OFS_IRQ_STATUS:
            s_axi_rdata <= {30'h0000_0000, irq_status};
          `OFS_IRQ_ENABLE:
            s_axi_rdata <= {30'h0000_0000, irq_enable};
          `OFS_CPU_CONTROL:
            s_axi_rdata <= {24'h00_0000, cpu_control};
          // holding and clear are write-only and read as zero
          default:
            s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers; sleep is left by hardware on a wake event
  always @(posedge clk_sys) begin
    if (rst) begin
      transmit_control <= `RST_TRANSMIT_CONTROL;
      receive_control  <= `RST_RECEIVE_CONTROL;
      baud_control     <= `RST_BAUD_CONTROL;
      cpu_control      <= `RST_CPU_CONTROL;
      irq_enable       <= {`IRQ_WIDTH{1'b0}};
    end else begin
      if (wr_lane0) begin
        case (aw_addr[7:0])
          `OFS_TRANSMIT_CONTROL:
            transmit_control <= w_data[7:0] & `TXC_WRITE_MASK;
          `OFS_RECEIVE_CONTROL:
            receive_control <= w_data[7:0] & `RXC_WRITE_MASK;
          `OFS_BAUD_CONTROL:
            baud_control <= w_data[7:0] & `BAUD_WRITE_MASK;
          `OFS_IRQ_ENABLE:
            irq_enable <= w_data[`IRQ_WIDTH-1:0];
          `OFS_CPU_CONTROL:
            cpu_control <= w_data[7:0] & `CPU_WRITE_MASK;
          default: ;
        endcase
      end
      // the wake path wins over a software write in the same cycle
      if (wake_cause)
        cpu_control[`CPU_SLEEP] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // holding register and shifter
  always @(posedge clk_sys) begin
    if (rst) begin
      transmit_holding        <= 8'h00;
      holding_full            <= 1'b0;
      transmit_shift_register <= 9'h000;
      shift_busy              <= 1'b0;
      bit_count               <= 4'h0;
      char_bits               <= `CHAR_BITS_EIGHT;
      dt_out                  <= 1'b1;
    end else if (!port_enable) begin
      // disabling the port drops everything queued or in flight
      holding_full <= 1'b0;
      shift_busy   <= 1'b0;
      bit_count    <= 4'h0;
      dt_out       <= 1'b1;
    end else begin
      if (wr_holding) begin
        transmit_holding <= w_data[7:0];
        holding_full     <= 1'b1;
      end
      if (!tx_active) begin
        // a clear of the enable aborts the character in the shifter
        shift_busy <= 1'b0;
        bit_count  <= 4'h0;
      end else if (load_shift) begin
        // ninth bit is sampled from control when the word is loaded
        transmit_shift_register <=
          {transmit_control[`TXC_NINTH_TRANSMIT_BIT],
           transmit_holding};
        char_bits <= transmit_control[`TXC_NINE_BIT_SELECT] ?
                     `CHAR_BITS_NINE : `CHAR_BITS_EIGHT;
        shift_busy   <= 1'b1;
        bit_count    <= 4'h0;
        dt_out       <= transmit_holding[0];
        if (!wr_holding)
          holding_full <= 1'b0;
      end else if (shift_busy) begin
        if (last_bit) begin
          shift_busy <= 1'b0;
          bit_count  <= 4'h0;
        end else if (trailing) begin
          bit_count <= bit_count + 4'h1;
        end else if (leading && bit_count != 4'h0) begin
          dt_out <= transmit_shift_register[bit_count];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // events, sticky status and the interrupt and wake outputs
  wire holding_freed = load_shift & ~wr_holding;
  wire wr_clear      = wr_lane0 & (aw_addr[7:0] == `OFS_IRQ_CLEAR);
  wire [`IRQ_WIDTH-1:0] clear_bits =
    wr_clear ? w_data[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};
  wire [`IRQ_WIDTH-1:0] set_bits;
  assign set_bits[`IRQ_BUFFER_EMPTY] = holding_freed;
  assign set_bits[`IRQ_CHAR_DONE]    = last_bit & tx_active;

  // a new holding word means the buffer is no longer free
  wire [`IRQ_WIDTH-1:0] write_clear;
  assign write_clear[`IRQ_BUFFER_EMPTY] = wr_holding;
  assign write_clear[`IRQ_CHAR_DONE]    = 1'b0;

  wire [`IRQ_WIDTH-1:0] next_irq_status =
    (irq_status & ~clear_bits & ~write_clear) | set_bits;

  // built from the next status so wake and service never outlive irq
  wire flag_enabled = next_irq_status[`IRQ_BUFFER_EMPTY] &
                      irq_enable[`IRQ_BUFFER_EMPTY] &
                      cpu_control[`CPU_PERIPHERAL_IE];
  assign wake_cause = flag_enabled & cpu_control[`CPU_SLEEP];

  always @(posedge clk_sys) begin
    if (rst) begin
      irq_status  <= {`IRQ_WIDTH{1'b0}};
      irq         <= 1'b0;
      sleeping    <= 1'b0;
      wake        <= 1'b0;
      isr_request <= 1'b0;
      ck_out      <= 1'b0;
      ck_oe_n     <= 1'b1;
      dt_oe_n     <= 1'b1;
    end else begin
      irq_status  <= next_irq_status;
      irq         <= |(next_irq_status & irq_enable);
      sleeping    <= cpu_control[`CPU_SLEEP] & ~wake_cause;
      wake        <= wake_cause;
      isr_request <= flag_enabled &
                     cpu_control[`CPU_GLOBAL_IE];
      ck_out      <= 1'b0;
      ck_oe_n     <= 1'b1;
      dt_oe_n     <= ~tx_active;
    end
  end

endmodule

`default_nettype wire

/* pkg/sync_slave_tx_defines.vh */
// register map, field positions and reset values of the slave transmitter
`ifndef SYNC_SLAVE_TX_DEFINES_VH
`define SYNC_SLAVE_TX_DEFINES_VH

// byte offsets on the register bus
`define OFS_TRANSMIT_CONTROL  8'h00
`define OFS_RECEIVE_CONTROL   8'h04
`define OFS_BAUD_CONTROL      8'h08
`define OFS_TRANSMIT_HOLDING  8'h0C
`define OFS_IRQ_STATUS        8'h10
`define OFS_IRQ_CLEAR         8'h14
`define OFS_IRQ_ENABLE        8'h18
`define OFS_CPU_CONTROL       8'h1C

// transmit_control fields
`define TXC_CLOCK_SOURCE_SELECT 7
`define TXC_NINE_BIT_SELECT     6
`define TXC_TRANSMIT_ENABLE     5
`define TXC_SYNC_MODE           4
`define TXC_SHIFT_EMPTY_STATUS  1
`define TXC_NINTH_TRANSMIT_BIT  0
`define TXC_WRITE_MASK          8'hF1

// receive_control fields
`define RXC_PORT_ENABLE         7
`define RXC_SINGLE_RECEIVE      5
`define RXC_CONTINUOUS_RECEIVE  4
`define RXC_WRITE_MASK          8'hB0

// baud_control fields
`define BAUD_CLOCK_POLARITY     4
`define BAUD_WRITE_MASK         8'h10

// interrupt status / clear / enable layout
`define IRQ_BUFFER_EMPTY        0
`define IRQ_CHAR_DONE           1
`define IRQ_WIDTH               2

// cpu_control fields
`define CPU_PERIPHERAL_IE       0
`define CPU_GLOBAL_IE           1
`define CPU_SLEEP               2
`define CPU_WRITE_MASK          8'h07

// reset values
`define RST_TRANSMIT_CONTROL    8'h00
`define RST_RECEIVE_CONTROL     8'h00
`define RST_BAUD_CONTROL        8'h00
`define RST_CPU_CONTROL         8'h00

// character lengths
`define CHAR_BITS_EIGHT         4'h8
`define CHAR_BITS_NINE          4'h9

// bus responses
`define RESP_OKAY               2'b00
`define RESP_SLVERR             2'b10

`endif

/* verif/shift_clock_master.sv */
// behavioural external master that clocks characters out of the slave
`timescale 1ns/1ps
`default_nettype none
module shift_clock_master (
  // request from the bench
  input  wire logic       go,
  input  wire logic [3:0] nbits,
  // idle level of the clock
  input  wire logic       pol,
  // link
  input  wire logic       dt,
  output wire logic       ck,
  // result
  output logic            done,
  output logic [8:0]      got
);
  logic toggle;

  // the leading edge always leaves the idle level
  assign ck = pol ^ toggle;

  initial begin
    toggle = 1'b0;
    done = 1'b1;
    got = 9'h000;
  end

  // clock idles at the pol level between characters, 125 ns period inside them
  always @(posedge go) begin
    done = 1'b0;
    got = 9'h000;
    for (int i = 0; i < nbits; i++) begin
      #62.5 toggle = 1'b1;
      #62.5 toggle = 1'b0;
      got[i] = dt;
    end
    #100 done = 1'b1;
  end
endmodule
`default_nettype wire

/* verif/sync_slave_tx_monitor.sv */
// concurrent checks on the slave transmitter ports
`timescale 1ns/1ps
`default_nettype none
module sync_slave_tx_monitor (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pins and power state
  input wire logic        ck_out,
  input wire logic        ck_oe_n,
  input wire logic        irq,
  input wire logic        sleeping,
  input wire logic        wake,
  input wire logic        isr_request
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ck_driver_off: assert property (ck_oe_n && !ck_out)
    else $error("clock pin driven by slave");
  a_isr_has_irq: assert property (isr_request |-> irq)
    else $error("service request without interrupt");
  a_wake_one_cycle: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  a_wake_ends_sleep: assert property (wake |-> ##[0:2] !sleeping)
    else $error("sleep not left after wake");
  a_wake_has_irq: assert property (wake |-> ##[0:1] irq)
    else $error("wake without interrupt");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind sync_slave_serial_transmitter sync_slave_tx_monitor mon_u (
  .clk_sys(clk_sys), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ck_out(ck_out), .ck_oe_n(ck_oe_n), .irq(irq), .sleeping(sleeping),
  .wake(wake), .isr_request(isr_request)
);
`default_nettype wire

/* verif/tb.sv */
// self-checking bench: register bus master, pin model and expectations
`timescale 1ns/1ps
`default_nettype none
`include "sync_slave_tx_defines.vh"
module tb;
  logic        clk_sys, rst, go, done, pol;
  logic [7:0]  awaddr, araddr, a;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, nbits;
  logic [1:0]  bresp, rresp, rr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        ck, ck_out, ck_oe_n, ck_pin, dt_out, dt_oe_n, dt_pin;
  logic        irq, sleeping, wake, isr_request;
  logic [8:0]  got;
  logic [4:0]  hs;
  logic [15:0] cfg [6];
  int          fails = 0, tests_run = 0, wakes = 0;
  int          q[$];

  // resolved pin levels; the data line has a pull-up
  assign ck_pin = ck_oe_n ? ck : ck_out;
  assign dt_pin = dt_oe_n ? 1'b1 : dt_out;
  assign hs = {done, bvalid, rvalid, arready, 1'b0};

  sync_slave_serial_transmitter dut_u (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ck_in(ck_pin), .ck_out(ck_out),
    .ck_oe_n(ck_oe_n), .dt_in(dt_pin), .dt_out(dt_out),
    .dt_oe_n(dt_oe_n), .irq(irq), .sleeping(sleeping), .wake(wake),
    .isr_request(isr_request)
  );

  shift_clock_master far_u (
    .go(go), .nbits(nbits), .pol(pol), .dt(dt_pin), .ck(ck), .done(done),
    .got(got)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) if (wake === 1'b1) wakes <= wakes + 1;

  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    tests_run++;
    if (act !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic wait_for(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hs[sel] !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      fails++;
      results();
    end
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] ad, input logic [7:0] d,
                    input logic [1:0] er);
    bit ta, tw;
    int n;
    ta = 0;
    tw = 0;
    n = 0;
    @(posedge clk_sys);
    awaddr <= ad;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw) && n < 3000) begin
      @(posedge clk_sys);
      n++;
      if (awready === 1'b1 && !ta) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !tw) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    if (!(ta && tw)) begin
      fails++;
      results();
    end
    wait_for(3);
    bready <= 1'b1;
    @(posedge clk_sys);
    check(32'(bresp), 32'(er));
    bready <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // rready raised late so the slave has to hold its answer
  task automatic rd_reg(input logic [7:0] ad);
    @(posedge clk_sys);
    araddr <= ad;
    arvalid <= 1'b1;
    wait_for(1);
    arvalid <= 1'b0;
    wait_for(2);
    rready <= 1'b1;
    @(posedge clk_sys);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e,
                        input logic [1:0] er);
    rd_reg(ad);
    check(rd, {24'h00_0000, e});
    check(32'(rr), 32'(er));
  endtask

  task automatic shift(input logic [3:0] nb, input logic [8:0] e);
    @(posedge clk_sys);
    nbits <= nb;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    wait_for(4);
    check(32'(got), 32'(e));
  endtask

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, go, pol} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    nbits = 4'h8;
    cfg = '{16'hA030, 16'h9030, 16'h0030, 16'h8020, 16'h80B0, 16'h8010};
    void'($urandom(19713));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(`OFS_TRANSMIT_CONTROL, 8'h02, `RESP_OKAY);
    rd_chk(`OFS_RECEIVE_CONTROL, `RST_RECEIVE_CONTROL, `RESP_OKAY);
    rd_chk(8'h20, 8'h00, `RESP_SLVERR);
    wr(8'h24, 8'hFF, `RESP_SLVERR);
    // one wrong mode bit each: the word must never go out
    foreach (cfg[i]) begin
      wr(`OFS_RECEIVE_CONTROL, cfg[i][15:8], `RESP_OKAY);
      wr(`OFS_TRANSMIT_CONTROL, cfg[i][7:0], `RESP_OKAY);
      wr(`OFS_TRANSMIT_HOLDING, 8'($urandom), `RESP_OKAY);
      repeat (20) @(posedge clk_sys);
      check(32'(dt_oe_n), 32'h0000_0001);
      rd_chk(`OFS_TRANSMIT_CONTROL, cfg[i][7:0] | 8'h02, `RESP_OKAY);
      wr(`OFS_RECEIVE_CONTROL, 8'h00, `RESP_OKAY);
    end
    wr(`OFS_IRQ_ENABLE, 8'h01, `RESP_OKAY);
    wr(`OFS_CPU_CONTROL, 8'h03, `RESP_OKAY);
    wr(`OFS_RECEIVE_CONTROL, 8'h80, `RESP_OKAY);
    wr(`OFS_TRANSMIT_CONTROL, 8'h30, `RESP_OKAY);
    repeat (2) q.push_back(int'(8'($urandom)));
    wr(`OFS_TRANSMIT_HOLDING, 8'(q[0]), `RESP_OKAY);
    wr(`OFS_TRANSMIT_HOLDING, 8'(q[1]), `RESP_OKAY);
    check(32'(dt_out), 32'(q[0] & 1));
    rd_chk(`OFS_IRQ_STATUS, 8'h00, `RESP_OKAY);
    rd_chk(`OFS_TRANSMIT_CONTROL, 8'h30, `RESP_OKAY);
    wr(`OFS_CPU_CONTROL, 8'h07, `RESP_OKAY);
    check(32'(sleeping), 32'h0000_0001);
    check(32'(irq), 32'h0000_0000);
    shift(4'h8, 9'(q.pop_front()));
    check(32'(wakes), 32'h0000_0001);
    check(32'(sleeping), 32'h0000_0000);
    check(32'(isr_request), 32'h0000_0001);
    rd_reg(`OFS_IRQ_STATUS);
    check(rd & 32'h0000_0001, 32'h0000_0001);
    shift(4'h8, 9'(q.pop_front()));
    // mask, unmask, then clear the pending flag
    wr(`OFS_IRQ_ENABLE, 8'h00, `RESP_OKAY);
    check(32'(irq), 32'h0000_0000);
    wr(`OFS_IRQ_ENABLE, 8'h01, `RESP_OKAY);
    check(32'(irq), 32'h0000_0001);
    wr(`OFS_IRQ_CLEAR, 8'h03, `RESP_OKAY);
    check(32'(irq), 32'h0000_0000);
    check(32'(isr_request), 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      a = 8'($urandom);
      wr(`OFS_TRANSMIT_CONTROL, 8'h70 | 8'(k), `RESP_OKAY);
      wr(`OFS_TRANSMIT_HOLDING, a, `RESP_OKAY);
      shift(4'h9, {k[0], a});
    end
    // idle-high clock: the leading edge is now the falling one
    wr(`OFS_BAUD_CONTROL, 8'h10, `RESP_OKAY);
    rd_chk(`OFS_BAUD_CONTROL, 8'h10, `RESP_OKAY);
    pol <= 1'b1;
    repeat (8) @(posedge clk_sys);
    a = 8'($urandom);
    wr(`OFS_TRANSMIT_CONTROL, 8'h30, `RESP_OKAY);
    wr(`OFS_TRANSMIT_HOLDING, a, `RESP_OKAY);
    shift(4'h8, {1'b0, a});
    results();
  end
endmodule
`default_nettype wire
